// [design/freq_prot_cfg.svh]
`ifndef FREQ_PROT_CFG_SVH
`define FREQ_PROT_CFG_SVH

// Register addresses.
`define ADDR_CFG_ENABLE  16'h009a
`define ADDR_MIN_CMD     16'h00d2
`define ADDR_SWITCH      16'h1519
`define ADDR_VMIN        16'h151a
`define ADDR_PICK50_BASE 16'h151b
`define ADDR_PICK60_BASE 16'h151c
`define ADDR_DELAY_BASE  16'h151d
`define ADDR_STRIDE      16'h0003
`define ADDR_MODE        16'h1600
`define ADDR_STATUS      16'h1601
`define ADDR_MASK        16'h1602
`define ADDR_LIVE        16'h1603
`define ADDR_NOMINAL     16'h1604

// Reset values.
`define RST_CFG_ENABLE   1'h1
`define RST_SWITCH       1'h0
`define RST_NOM60        1'h1
`define RST_VMIN         16'h0041
`define RST_MODE         4'h8
`define RST_MIN_CMD      16'h000f
`define RST_MASK         11'h000
`define RST_PICK60       64'h17d4_1676_170c_173e
`define RST_PICK50       64'h13ec_128e_1324_1356
`define RST_DELAY        {14'h0bb8, 14'h012c, 14'h0bb8, 14'h1770}

// Setting ranges, frequencies in 0.01 Hz, voltage in V, delay in 10 ms.
`define VMIN_LO          16'h0028
`define VMIN_HI          16'h0078
`define F60_LO           16'h15ae
`define F60_HI           16'h1932
`define F50_LO           16'h11c6
`define F50_HI           16'h154a
`define DELAY_HI         16'h2710
`define NOM60            16'h1770
`define NOM50            16'h1388

// Status and live-status field positions.
`define ST_PICKUP        0
`define ST_TRIP          4
`define ST_UVBLK         8
`define ST_BLOCKED       9
`define ST_OFF           10

// Timing: one tick is 10 ms at a 10 ns clock.
`define CLK_PERIOD_NS    10
`define TICK_TIME_MS     10
`define TICK_COUNT       ((`TICK_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// [design/freq_prot_pkg.sv]
package freq_prot_pkg;

  typedef logic [10:0] event_t;

  typedef struct packed {
    logic        picked;
    logic        trip;
    logic [13:0] dcnt;
    logic [15:0] hcnt;
  } elem_state_s;

  typedef struct packed {
    logic             cfg_en;
    logic             fn_sw;
    logic             nom60;
    logic [15:0]      vmin;
    logic [3:0][15:0] pick;
    logic [3:0][13:0] dly;
    logic [3:0]       mode;
    logic [15:0]      min_cmd;
    event_t           status;
    event_t           mask;
    event_t           prev;
    logic [15:0]      rdata;
    logic [19:0]      tick_cnt;
    logic             tick;
    logic             off;
    logic             blocked;
    logic             active;
    logic             uv;
  } ctrl_state_s;

endpackage : freq_prot_pkg

// [design/freq_element.sv]
`timescale 1ns/1ps
`default_nettype none

// One definite-time frequency element with pickup, delay and command hold.
module freq_element (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic        en,
  input  wire logic        over,
  input  wire logic [15:0] setting,
  input  wire logic [15:0] nominal,
  input  wire logic [15:0] freq,
  input  wire logic [13:0] delay,
  input  wire logic [15:0] min_cmd,
  output logic             pickup,
  output logic             trip
);
  freq_prot_pkg::elem_state_s s;
  freq_prot_pkg::elem_state_s next_s;
  logic                       armed;

  // A setting equal to nominal parks the element while that setting stands.
  assign armed = en && (setting != nominal); // R10

  // Pickup holds until the frequency crosses back over the setting.
  always_comb begin
    next_s = s;
    if (!armed) begin
      next_s.picked = 1'b0;
    end else if (over) begin
      next_s.picked = s.picked ? (freq >= setting) : (freq > setting); // R4
    end else begin
      next_s.picked = s.picked ? (freq <= setting) : (freq < setting); // R3
    end
    // Delay counts ticks only; the size of the deviation never matters.
    if (!next_s.picked) begin
      next_s.dcnt = '0;
    end else if (tick && (s.dcnt < delay)) begin
      next_s.dcnt = s.dcnt + 14'h0001; // R8
    end
    // The command stays up for the minimum duration even after dropout.
    if (!s.trip) begin
      next_s.hcnt = '0;
      next_s.trip = s.picked && next_s.picked && (s.dcnt >= delay); // R5
    end else begin
      if (tick && (s.hcnt < min_cmd)) begin
        next_s.hcnt = s.hcnt + 16'h0001;
      end
      next_s.trip = next_s.picked || (s.hcnt < min_cmd); // R6
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pickup = s.picked;
  assign trip   = s.trip;

  property p_inactive;
    @(posedge sys_clk) disable iff (!rst_b)
    (setting == nominal) |=> !pickup;
  endproperty
  a_inactive: assert property (p_inactive) // R10
    else $error("Element at nominal setting picked up.");

  property p_trip_cause;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(trip) |-> ($past(pickup) && ($past(s.dcnt) >= $past(delay)));
  endproperty
  a_trip_cause: assert property (p_trip_cause) // R5
    else $error("Trip rose without an expired delay.");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    (trip && (s.hcnt < min_cmd) && $stable(min_cmd)) |=> trip;
  endproperty
  a_hold: assert property (p_hold) // R6
    else $error("Trip ended before minimum command duration.");

  property p_definite;
    @(posedge sys_clk) disable iff (!rst_b)
    (!trip && (s.dcnt < delay)) |=> !trip;
  endproperty
  a_definite: assert property (p_definite) // R8
    else $error("Trip issued before the delay count was reached.");

endmodule : freq_element

`default_nettype wire

// [design/freq_protection.sv]
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "freq_prot_cfg.svh"

// Contract
// (R1) Four elements, each set on its own as over- or underfrequency.
// (R2) Function blocked while positive-sequence voltage is below minimum.
// (R3) Underfrequency element picks up below setting, drops above it.
// (R4) Overfrequency element picks up above setting, drops below it.
// (R5) Per-element delay starts at pickup; expiry while picked up trips.
// (R6) Trip ends on dropout but not before minimum command duration.
// (R7) A per-element block input inhibits that element alone.
// (R8) Delays are definite time, independent of frequency deviation.
// (R9) Function works only when configured enabled and switched on.
// (R10) Element set to nominal frequency never picks up or trips.
// (R11) 60 Hz pickups sit at 5404 stride three, range 55.50-64.50 Hz.
// (R12) 50 Hz pickups sit at 5403 stride three, range 45.50-54.50 Hz.
// (R13) Delays sit at 5405, 5408, 5411, 5414 for both variants.
// (R14) Software should set over elements above, under elements below nominal.
// (R15) A distinct indication shows blocking by low voltage.
// (R16) One external input blocks the entire function.
// (R17) Pickup, trip, off, blocked and active reported as event flags; here active is only a live flag, and undervoltage block is an event.
module freq_protection #(
  parameter logic [19:0] TICK_CYCLES = 20'(`TICK_COUNT)
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] freq_meas,
  input  wire logic [15:0] volt_meas,
  input  wire logic        function_block_input,
  input  wire logic [3:0]  elem_block,
  output logic      [3:0]  pickup,
  output logic      [3:0]  trip,
  output logic             fn_off,
  output logic             fn_blocked,
  output logic             fn_active,
  output logic             uv_block,
  output logic             irq
);

  localparam freq_prot_pkg::ctrl_state_s RST_S = '{
    cfg_en:  `RST_CFG_ENABLE,
    fn_sw:   `RST_SWITCH,
    nom60:   `RST_NOM60,
    vmin:    `RST_VMIN,
    pick:    `RST_PICK60,
    dly:     `RST_DELAY,
    mode:    `RST_MODE,
    min_cmd: `RST_MIN_CMD,
    mask:    `RST_MASK,
    default: '0
  };

  freq_prot_pkg::ctrl_state_s s;
  freq_prot_pkg::ctrl_state_s next_s;
  freq_prot_pkg::event_t      cur_ind;
  freq_prot_pkg::event_t      events;
  logic [2:0]                 pick_hit;
  logic [2:0]                 dly_hit;
  logic [15:0]                pick_base;
  logic [15:0]                nominal;
  logic [15:0]                f_lo;
  logic [15:0]                f_hi;
  logic [3:0]                 elem_en;
  logic                       fn_on;
  logic                       uv_now;
  logic                       blk_now;

  // Finds which of the four strided setting slots an address selects.
  function automatic logic [2:0] slot_of(input logic [15:0] addr,
                                         input logic [15:0] base);
    logic [15:0] a;
    slot_of = 3'h0;
    for (int k = 0; k < 4; k++) begin
      a = base + `ADDR_STRIDE * 16'(k);
      if (addr == a) begin
        slot_of = {1'b1, 2'(k)};
      end
    end
  endfunction : slot_of

  // Settings outside their range are refused, the old value stays.
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // The pickup slots move with the nominal frequency variant.
  assign pick_base = s.nom60 ? `ADDR_PICK60_BASE : `ADDR_PICK50_BASE;
  assign nominal   = s.nom60 ? `NOM60 : `NOM50;
  assign f_lo      = s.nom60 ? `F60_LO : `F50_LO;
  assign f_hi      = s.nom60 ? `F60_HI : `F50_HI;
  assign pick_hit  = slot_of(reg_addr, pick_base); // R11 R12
  assign dly_hit   = slot_of(reg_addr, `ADDR_DELAY_BASE); // R13

  // Function-wide gating: configuration, switch, undervoltage, block input.
  assign fn_on   = s.cfg_en && s.fn_sw; // R9
  assign uv_now  = fn_on && (volt_meas < s.vmin); // R2
  assign blk_now = fn_on && (uv_now || function_block_input); // R16

  // Live indications; every bit here is a flip-flop output.
  assign cur_ind = {s.off, s.blocked, s.uv, trip, pickup};
  assign events  = cur_ind & ~s.prev; // R17

  // Four identical elements, each with its own block input.
  for (genvar i = 0; i < 4; i++) begin : g_elem
    assign elem_en[i] = fn_on && !blk_now && !elem_block[i]; // R7
    freq_element u_elem (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .tick    (s.tick),
      .en      (elem_en[i]),
      .over    (s.mode[i]),
      .setting (s.pick[i]),
      .nominal (nominal),
      .freq    (freq_meas),
      .delay   (s.dly[i]),
      .min_cmd (s.min_cmd),
      .pickup  (pickup[i]),
      .trip    (trip[i])
    );
  end

  // Next state: time base, register writes, flags and read data.
  always_comb begin
    next_s = s;
    // A 10 ms tick drives all element timers; one shared divider saves area.
    next_s.tick = 1'b0;
    if (s.tick_cnt >= TICK_CYCLES - 20'h00001) begin
      next_s.tick_cnt = '0;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 20'h00001;
    end
    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_CFG_ENABLE: begin
          next_s.cfg_en = reg_wdata[0]; // R9
        end
        `ADDR_SWITCH: begin
          next_s.fn_sw = reg_wdata[0]; // R9
        end
        `ADDR_VMIN: begin
          if (in_range(reg_wdata, `VMIN_LO, `VMIN_HI)) begin
            next_s.vmin = reg_wdata; // R2
          end
        end
        `ADDR_MIN_CMD: begin
          next_s.min_cmd = reg_wdata; // R6
        end
        `ADDR_MODE: begin
          next_s.mode = reg_wdata[3:0]; // R1
        end
        `ADDR_MASK: begin
          next_s.mask = reg_wdata[10:0];
        end
        `ADDR_NOMINAL: begin
          // Old pickups would be out of range, so reload the defaults.
          next_s.nom60 = reg_wdata[0];
          next_s.pick  = reg_wdata[0] ? `RST_PICK60 : `RST_PICK50;
        end
        default: begin
        end
      endcase
      if (pick_hit[2] && in_range(reg_wdata, f_lo, f_hi)) begin
        next_s.pick[pick_hit[1:0]] = reg_wdata; // R11 R12
      end
      if (dly_hit[2] && (reg_wdata <= `DELAY_HI)) begin
        next_s.dly[dly_hit[1:0]] = reg_wdata[13:0]; // R13
      end
    end
    // Registered function indications.
    next_s.off     = !fn_on; // R17
    next_s.blocked = blk_now;
    next_s.active  = fn_on && !blk_now;
    next_s.uv      = uv_now; // R15
    next_s.prev    = cur_ind;
    // Sticky status; a new event in the reading cycle survives the clear.
    if (reg_rd && (reg_addr == `ADDR_STATUS)) begin
      next_s.status = events; // R17
    end else begin
      next_s.status = s.status | events;
    end
    // Read data stand for exactly the cycle after the read strobe.
    next_s.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CFG_ENABLE: begin
          next_s.rdata = {15'h0000, s.cfg_en};
        end
        `ADDR_SWITCH: begin
          next_s.rdata = {15'h0000, s.fn_sw};
        end
        `ADDR_VMIN: begin
          next_s.rdata = s.vmin;
        end
        `ADDR_MIN_CMD: begin
          next_s.rdata = s.min_cmd;
        end
        `ADDR_MODE: begin
          next_s.rdata = {12'h000, s.mode};
        end
        `ADDR_STATUS: begin
          next_s.rdata = {5'h00, s.status};
        end
        `ADDR_MASK: begin
          next_s.rdata = {5'h00, s.mask};
        end
        `ADDR_LIVE: begin
          next_s.rdata = {4'h0, s.active, cur_ind};
        end
        `ADDR_NOMINAL: begin
          next_s.rdata = {15'h0000, s.nom60};
        end
        default: begin
        end
      endcase
      if (pick_hit[2]) begin
        next_s.rdata = s.pick[pick_hit[1:0]];
      end
      if (dly_hit[2]) begin
        next_s.rdata = {2'h0, s.dly[dly_hit[1:0]]};
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  // Outputs.
  assign reg_rdata  = s.rdata;
  assign fn_off     = s.off;
  assign fn_blocked = s.blocked;
  assign fn_active  = s.active;
  assign uv_block   = s.uv;
  assign irq        = |(s.status & s.mask);

  property p_mode_write;
    @(posedge sys_clk) disable iff (!rst_b)
    (reg_wr && (reg_addr == `ADDR_MODE)) |=>
      (s.mode == $past(reg_wdata[3:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) // R1
    else $error("Element mode write did not land.");

  property p_uv_block;
    @(posedge sys_clk) disable iff (!rst_b)
    (fn_on && (volt_meas < s.vmin)) |=>
      (uv_block && fn_blocked && (pickup == 4'h0));
  endproperty
  a_uv_block: assert property (p_uv_block) // R2
    else $error("Low voltage did not block the function.");

  property p_under;
    @(posedge sys_clk) disable iff (!rst_b)
    (elem_en[0] && !s.mode[0] && (s.pick[0] != nominal)
      && (freq_meas < s.pick[0])) |=> pickup[0];
  endproperty
  a_under: assert property (p_under) // R3
    else $error("Underfrequency element 1 failed to pick up.");

  property p_over;
    @(posedge sys_clk) disable iff (!rst_b)
    (elem_en[3] && s.mode[3] && (s.pick[3] != nominal)
      && (freq_meas > s.pick[3])) |=> pickup[3];
  endproperty
  a_over: assert property (p_over) // R4
    else $error("Overfrequency element 4 failed to pick up.");

  property p_elem_block;
    @(posedge sys_clk) disable iff (!rst_b)
    (elem_block != 4'h0) |=> ((pickup & $past(elem_block)) == 4'h0);
  endproperty
  a_elem_block: assert property (p_elem_block) // R7
    else $error("Blocked element is picked up.");

  property p_off;
    @(posedge sys_clk) disable iff (!rst_b)
    (rst_b && !(s.cfg_en && s.fn_sw)) |=>
      (fn_off && !fn_active && (pickup == 4'h0));
  endproperty
  a_off: assert property (p_off) // R9
    else $error("Function acted while disabled or switched off.");

  property p_pick_range;
    @(posedge sys_clk) disable iff (!rst_b)
    (reg_wr && pick_hit[2] && !in_range(reg_wdata, f_lo, f_hi)) |=>
      $stable(s.pick);
  endproperty
  a_pick_range: assert property (p_pick_range) // R11 R12
    else $error("Out-of-range pickup setting was accepted.");

  property p_delay_write;
    @(posedge sys_clk) disable iff (!rst_b)
    (reg_wr && dly_hit[2] && (reg_wdata <= `DELAY_HI)) |=>
      (s.dly[$past(dly_hit[1:0])] == $past(reg_wdata[13:0]));
  endproperty
  a_delay_write: assert property (p_delay_write) // R13
    else $error("Delay setting write did not land.");

  property p_uv_event;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(uv_block) |=> s.status[`ST_UVBLK];
  endproperty
  a_uv_event: assert property (p_uv_event) // R15
    else $error("Undervoltage block event was not flagged.");

  property p_ext_block;
    @(posedge sys_clk) disable iff (!rst_b)
    (fn_on && function_block_input) |=>
      (fn_blocked && !fn_active && (pickup == 4'h0));
  endproperty
  a_ext_block: assert property (p_ext_block) // R16
    else $error("Function block input did not block.");

  property p_events;
    @(posedge sys_clk) disable iff (!rst_b)
    ((cur_ind & ~s.prev) != 11'h000) |=> (s.status != 11'h000);
  endproperty
  a_events: assert property (p_events) // R17
    else $error("Indication edge did not set a status flag.");

endmodule : freq_protection

`default_nettype wire

// [verification/grid_source_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the frequency and voltage measurements and the station's binary inputs.
// A new reading shows one clock after the bench asks for it.
module grid_source_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] want_freq,
  input  wire logic [15:0] want_volt,
  input  wire logic        want_blk_all,
  input  wire logic [3:0]  want_blk_el,
  output logic      [15:0] freq_meas,
  output logic      [15:0] volt_meas,
  output logic             function_block_input,
  output logic      [3:0]  elem_block
);
  // Registered so that every reading changes just after a clock edge.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_meas            <= 16'h0000;
      volt_meas            <= 16'h0000;
      function_block_input <= 1'b0;
      elem_block           <= 4'h0;
    end else begin
      freq_meas            <= want_freq;
      volt_meas            <= want_volt;
      function_block_input <= want_blk_all;
      elem_block           <= want_blk_el;
    end
  end
endmodule : grid_source_model
`default_nettype wire

// [verification/test_freq_protection.sv]
`timescale 1ns/1ps
`default_nettype none
`include "freq_prot_cfg.svh"

// Self-checking bench; ticks are shortened to ten clocks.
module test_freq_protection;
  logic        sys_clk;
  logic        rst_b;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] freq_meas;
  logic [15:0] volt_meas;
  logic        function_block_input;
  logic [3:0]  elem_block;
  logic [3:0]  pickup;
  logic [3:0]  trip;
  logic        fn_off;
  logic        fn_blocked;
  logic        fn_active;
  logic        uv_block;
  logic        irq;
  logic [15:0] want_freq;
  logic [15:0] want_volt;
  logic        want_blk_all;
  logic [3:0]  want_blk_el;
  logic [12:0] obs;
  int          fail_count;
  int          total_checks;
  int          cycles = 0;
  int          n;

  // Flags gathered so one wait task serves them all.
  assign obs = {irq, uv_block, fn_active, fn_blocked, fn_off, trip, pickup};

  freq_protection #(.TICK_CYCLES(20'h0000a)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .freq_meas(freq_meas), .volt_meas(volt_meas),
    .function_block_input(function_block_input), .elem_block(elem_block),
    .pickup(pickup), .trip(trip), .fn_off(fn_off),
    .fn_blocked(fn_blocked), .fn_active(fn_active),
    .uv_block(uv_block), .irq(irq));

  grid_source_model grid (
    .sys_clk(sys_clk), .rst_b(rst_b), .want_freq(want_freq),
    .want_volt(want_volt), .want_blk_all(want_blk_all),
    .want_blk_el(want_blk_el), .freq_meas(freq_meas),
    .volt_meas(volt_meas), .function_block_input(function_block_input),
    .elem_block(elem_block));

  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // A hung wait would otherwise run forever; the whole run needs ~400.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int got, input int lo, input int hi,
                         input string msg);
    total_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("wrong value at %0t: %s took %0d cycles", $time, msg, got);
    end
  endtask : chk_cnt

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [15:0] a, input logic [15:0] exp,
                      input string msg);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp, msg);
  endtask : rchk

  task automatic wrc(input logic [15:0] a, input logic [15:0] v,
                     input logic [15:0] exp);
    wr(a, v);
    rchk(a, exp, "setting");
  endtask : wrc

  task automatic go(input logic [15:0] f, input logic [15:0] v,
                    input logic ba, input logic [3:0] be);
    @(posedge sys_clk);
    want_freq    <= f;
    want_volt    <= v;
    want_blk_all <= ba;
    want_blk_el  <= be;
    #1;
  endtask : go

  task automatic wait_for(input int idx, input logic val, output int cnt);
    cnt = 0;
    while (obs[idx] !== val && cnt < 300) begin
      step(1);
      cnt++;
    end
  endtask : wait_for

  task automatic reset_values;
    chk(16'(fn_off), 16'h0001, "off at start");
    rchk(`ADDR_SWITCH, 16'h0000, "switch");
    rchk(`ADDR_VMIN, `RST_VMIN, "vmin");
    rchk(`ADDR_MODE, 16'h0008, "mode");
    rchk(`ADDR_PICK60_BASE, 16'h173e, "pick1");
    rchk(16'h1526, 16'h0bb8, "delay4");
    rchk(16'h1234, 16'h0000, "unmapped");
  endtask : reset_values

  task automatic ranges;
    wrc(`ADDR_VMIN, 16'h0027, 16'h0041);
    wrc(`ADDR_VMIN, 16'h0028, 16'h0028);
    wrc(`ADDR_VMIN, 16'h0079, 16'h0028);
    wrc(`ADDR_VMIN, 16'h0078, 16'h0078);
    wrc(`ADDR_VMIN, 16'h0041, 16'h0041);
    wrc(16'h151f, 16'h15ad, 16'h170c);
    wrc(16'h151f, 16'h1933, 16'h170c);
    wrc(16'h151f, 16'h1932, 16'h1932);
    wrc(16'h151f, 16'h170c, 16'h170c);
    wrc(16'h1520, 16'h2711, 16'h0bb8);
    wrc(16'h1520, 16'h2710, 16'h2710);
  endtask : ranges

  task automatic setup;
    wr(`ADDR_SWITCH, 16'h0001);
    wr(`ADDR_MIN_CMD, 16'h0003);
    wr(16'h1523, 16'h0002);
    step(2);
    chk(16'(obs[10:8]), 16'h0004, "switched on");
    wr(`ADDR_CFG_ENABLE, 16'h0000);
    step(2);
    chk(16'(obs[10:8]), 16'h0001, "not configured");
    wr(`ADDR_CFG_ENABLE, 16'h0001);
    step(2);
  endtask : setup

  // Element 3 has a two-tick delay and a three-tick minimum command.
  task automatic under_trip;
    go(16'h1644, 16'h0064, 1'b0, 4'h0);
    wait_for(0, 1'b1, n);
    chk_cnt(n, 2, 2, "pickup latency");
    chk(16'(pickup), 16'h0007, "under pickups");
    wait_for(6, 1'b1, n);
    chk_cnt(n, 10, 22, "trip delay");
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    wait_for(6, 1'b0, n);
    chk_cnt(n, 19, 34, "short trip held");
    go(16'h15e0, 16'h0064, 1'b0, 4'h0);
    wait_for(2, 1'b1, n);
    chk_cnt(n, 2, 2, "dip pickup");
    wait_for(6, 1'b1, n);
    chk_cnt(n, 10, 22, "deep dip delay");
    step(40);
    go(16'h1676, 16'h0064, 1'b0, 4'h0);
    step(4);
    chk(16'(pickup), 16'h0007, "equal holds");
    go(16'h1677, 16'h0064, 1'b0, 4'h0);
    wait_for(6, 1'b0, n);
    chk_cnt(n, 1, 4, "trip end");
    chk(16'(pickup), 16'h0003, "rise above");
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    step(4);
  endtask : under_trip

  // Element 4 is over at 61.00 Hz, above nominal as recommended.
  task automatic over_mode;
    go(16'h17d4, 16'h0064, 1'b0, 4'h0);
    step(4);
    chk(16'(pickup), 16'h0000, "equal no pickup");
    go(16'h17d5, 16'h0064, 1'b0, 4'h0);
    wait_for(3, 1'b1, n);
    chk_cnt(n, 2, 2, "over latency");
    go(16'h17d4, 16'h0064, 1'b0, 4'h0);
    step(4);
    chk(16'(pickup), 16'h0008, "over holds");
    go(16'h17d3, 16'h0064, 1'b0, 4'h0);
    wait_for(3, 1'b0, n);
    chk_cnt(n, 2, 2, "over dropout");
    wr(`ADDR_MODE, 16'h000f);
    go(16'h1838, 16'h0064, 1'b0, 4'h0);
    step(4);
    chk(16'(pickup), 16'h000f, "all over");
    wr(`ADDR_MODE, 16'h0008);
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    step(4);
  endtask : over_mode

  task automatic blocks;
    go(16'h1644, 16'h0064, 1'b0, 4'h2);
    step(4);
    chk(16'(pickup), 16'h0005, "element block");
    go(16'h1644, 16'h0064, 1'b1, 4'h0);
    step(4);
    chk(16'(obs[10:0]), 16'h0200, "function block");
    go(16'h1644, 16'h0040, 1'b0, 4'h0);
    step(4);
    chk(16'(obs[11:0]), 16'h0a00, "low voltage");
    go(16'h1644, 16'h0041, 1'b0, 4'h0);
    step(4);
    chk(16'(obs[11:0]), 16'h0407, "voltage at min");
    rchk(`ADDR_LIVE, 16'h0807, "live flags");
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    step(4);
  endtask : blocks

  task automatic irq_events;
    logic [15:0] v;
    rd(`ADDR_STATUS, v);
    wr(`ADDR_MASK, 16'h0100);
    go(16'h1770, 16'h0040, 1'b0, 4'h0);
    wait_for(12, 1'b1, n);
    chk_cnt(n, 2, 4, "irq raise");
    rd(`ADDR_STATUS, v);
    chk(16'(v[8]), 16'h0001, "uv event");
    step(1);
    chk(16'(irq), 16'h0000, "irq cleared");
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    wr(`ADDR_MASK, 16'h0000);
    go(16'h1770, 16'h0040, 1'b0, 4'h0);
    step(4);
    chk(16'(irq), 16'h0000, "irq masked");
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    step(4);
    rd(`ADDR_STATUS, v);
    wr(`ADDR_MASK, 16'h000f);
    go(16'h1644, 16'h0064, 1'b0, 4'h0);
    step(4);
    chk(16'(irq), 16'h0001, "pickup irq");
    rchk(`ADDR_STATUS, 16'h0007, "pickup events");
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    step(30);
  endtask : irq_events

  task automatic inactive_and_50hz;
    wrc(`ADDR_PICK60_BASE, 16'h1770, 16'h1770);
    go(16'h1644, 16'h0064, 1'b0, 4'h0);
    step(30);
    chk(16'({pickup[0], trip[0]}), 16'h0000, "nominal set");
    go(16'h1770, 16'h0064, 1'b0, 4'h0);
    wr(`ADDR_NOMINAL, 16'h0000);
    rchk(`ADDR_PICK50_BASE, 16'h1356, "pick1 50");
    rchk(`ADDR_PICK60_BASE, 16'h0000, "60 not decoded");
    wrc(`ADDR_PICK50_BASE, 16'h11c5, 16'h1356);
    wrc(`ADDR_PICK50_BASE, 16'h11c6, 16'h11c6);
    rchk(16'h1523, 16'h0002, "shared delay");
    go(16'h1194, 16'h0064, 1'b0, 4'h0);
    step(4);
    chk(16'(pickup), 16'h0007, "50 hz under");
    go(16'h1388, 16'h0064, 1'b0, 4'h0);
    wr(`ADDR_NOMINAL, 16'h0001);
    rchk(`ADDR_PICK60_BASE, 16'h173e, "reloaded");
  endtask : inactive_and_50hz

  // Main sequence.
  initial begin
    rst_b        = 1'b0;
    reg_addr     = 16'h0000;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    want_freq    = 16'h1770;
    want_volt    = 16'h0064;
    want_blk_all = 1'b0;
    want_blk_el  = 4'h0;
    fail_count   = 0;
    total_checks = 0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    step(2);
    reset_values();
    ranges();
    setup();
    under_trip();
    over_mode();
    blocks();
    irq_events();
    inactive_and_50hz();
    close_out();
  end
endmodule : test_freq_protection
`default_nettype wire
